// [shared/can_port_pkg.sv]
// constants, field layouts and types for the can port i/o and status led block
// assumes a 100 MHz system clock and an apb register bus with 32-bit data
package can_port_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_XCVR_CTRL = 8'h00;
    localparam logic [7:0] OFS_XCVR_STAT = 8'h04;
    localparam logic [7:0] OFS_EXP_DIR = 8'h08;
    localparam logic [7:0] OFS_EXP_OUT = 8'h0C;
    localparam logic [7:0] OFS_EXP_IN = 8'h10;
    localparam logic [7:0] OFS_CHAN = 8'h14;
    localparam logic [7:0] OFS_SYS = 8'h18;
    localparam logic [7:0] OFS_LED = 8'h1C;
    // field positions
    localparam int unsigned XC_EN_BIT = 0;
    localparam int unsigned XC_STB_BIT = 1;
    localparam int unsigned XC_SW_BIT = 2;
    localparam int unsigned XC_TIED_BIT = 3;
    localparam int unsigned ST_ERR_BIT = 0;
    localparam int unsigned ST_TERM_BIT = 1;
    localparam int unsigned CHAN_ERR_POS = 8;
    localparam int unsigned SYS_LOGIN_BIT = 0;
    localparam int unsigned SYS_CABLE_BIT = 1;
    localparam int unsigned SYS_FW_BIT = 2;
    localparam int unsigned LED_STATE_POS = 8;
    // values after reset
    localparam logic XCVR_EN_RST = 1'b1;
    localparam logic XCVR_STB_RST = 1'b1;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
    // timing
    localparam int unsigned CLK_KHZ = 100_000;
    localparam int unsigned TRAFFIC_MS = 256;
    localparam int unsigned TRAFFIC_CYC = TRAFFIC_MS * CLK_KHZ;
    localparam int unsigned PAT1_ON_CYC = 25_000_000;
    localparam int unsigned PAT1_OFF_CYC = 25_000_000;
    localparam int unsigned PAT2_ON_CYC = 10_000_000;
    localparam int unsigned PAT2_OFF_CYC = 10_000_000;
    localparam int unsigned PAT3_ON_CYC = 5_000_000;
    localparam int unsigned PAT3_OFF_CYC = 5_000_000;
    // transceiver control register image
    typedef struct packed {
        logic tied;
        logic single_wire;
        logic standby_n;
        logic enable;
    } xcvr_ctrl_t;
    // host-side system status image
    typedef struct packed {
        logic fw_update;
        logic cable_absent;
        logic logged_in;
    } sys_t;
    // state indicator modes
    typedef enum logic [4:0] {
        LED_OFF = 5'b00001,
        LED_ON = 5'b00010,
        LED_PAT1 = 5'b00100,
        LED_PAT2 = 5'b01000,
        LED_PAT3 = 5'b10000
    } led_mode_t;
endpackage

// [design/can_port_io.sv]
// can port i/o: transceiver mode lines, expansion port and per-channel leds
// assumes an apb master on REF_CLK; frame and bus error events come as
// one-cycle pulses from can controller logic on the same clock
`timescale 1ns/100ps
`default_nettype none
module can_port_io #(
    parameter int unsigned NCH = 2,
    parameter int unsigned EXP_W = 8,
    parameter int unsigned TRAFFIC_CYC = can_port_pkg::TRAFFIC_CYC,
    parameter int unsigned PAT1_ON = can_port_pkg::PAT1_ON_CYC,
    parameter int unsigned PAT1_OFF = PAT1_ON,
    parameter int unsigned PAT2_ON = can_port_pkg::PAT2_ON_CYC,
    parameter int unsigned PAT2_OFF = PAT2_ON,
    parameter int unsigned PAT3_ON = can_port_pkg::PAT3_ON_CYC,
    parameter int unsigned PAT3_OFF = PAT3_ON
) (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic XCVR_EN_OUT,
    output logic XCVR_STANDBY_N_OUT,
    input wire logic XCVR_ERR_N_IN,
    input wire logic TERM_SENSE_IN,
    input wire logic [EXP_W-1:0] EXP_PIN_IN,
    output logic [EXP_W-1:0] EXP_PIN_OUT,
    output logic [EXP_W-1:0] EXP_PIN_OE,
    input wire logic [NCH-1:0] FRAME_EVT,
    input wire logic [NCH-1:0] BUS_ERR_EVT,
    output logic [NCH-1:0] TRAFFIC_LED,
    output logic [NCH-1:0] STATE_LED
);
    localparam logic [31:0] PAT_ON [3] = '{PAT1_ON, PAT2_ON, PAT3_ON};
    localparam logic [31:0] PAT_OFF [3] = '{PAT1_OFF, PAT2_OFF, PAT3_OFF};
    localparam logic [31:0] TRAFFIC_LEN = TRAFFIC_CYC;
    localparam logic [31:0] TRAFFIC_HALF = TRAFFIC_LEN >> 1;

    can_port_pkg::xcvr_ctrl_t ctrl;
    can_port_pkg::sys_t sys;
    logic [1:0] err_sync;
    logic [1:0] term_sync;
    logic [EXP_W-1:0] exp_meta;
    logic [EXP_W-1:0] exp_in;
    logic [NCH-1:0] chan_init;
    logic [NCH-1:0] chan_err;
    logic [31:0] traffic_cnt [NCH];
    logic [31:0] pat_cnt [3];
    logic [2:0] pat_lvl;
    can_port_pkg::led_mode_t mode [NCH];
    logic setup_phase;
    logic wr_hit;
    logic err_seen;
    logic [31:0] next_rdata;
    logic next_slverr;

    // state led mode by priority: update, login, error, init
    function automatic can_port_pkg::led_mode_t pick_mode(input can_port_pkg::sys_t s, input logic init,
                                                          input logic err);
        if (s.fw_update) begin
            pick_mode = can_port_pkg::LED_PAT3;
        end else if (!s.logged_in || s.cable_absent) begin
            pick_mode = can_port_pkg::LED_PAT1;
        end else if (err) begin
            pick_mode = can_port_pkg::LED_PAT2;
        end else if (!init) begin
            pick_mode = can_port_pkg::LED_ON;
        end else begin
            pick_mode = can_port_pkg::LED_OFF;
        end
    endfunction

    // apb handshake: one access cycle, decided in the setup cycle
    assign setup_phase = PSEL && !PENABLE;
    assign wr_hit = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
    // error line is meaningless on the single-wire part, so report idle
    assign err_seen = ctrl.single_wire ? 1'b1 : err_sync[1];

    // read mux and unmapped-address decode
    always_comb begin
        next_rdata = can_port_pkg::DATA_ZERO;
        next_slverr = 1'b0;
        case (PADDR)
            can_port_pkg::OFS_XCVR_CTRL: begin
                next_rdata[3:0] = ctrl;
            end
            can_port_pkg::OFS_XCVR_STAT: begin
                next_rdata[can_port_pkg::ST_ERR_BIT] = err_seen;
                next_rdata[can_port_pkg::ST_TERM_BIT] = term_sync[1];
            end
            can_port_pkg::OFS_EXP_DIR: begin
                next_rdata[EXP_W-1:0] = EXP_PIN_OE;
            end
            can_port_pkg::OFS_EXP_OUT: begin
                next_rdata[EXP_W-1:0] = EXP_PIN_OUT;
            end
            can_port_pkg::OFS_EXP_IN: begin
                next_rdata[EXP_W-1:0] = exp_in;
            end
            can_port_pkg::OFS_CHAN: begin
                next_rdata[NCH-1:0] = chan_init;
                next_rdata[can_port_pkg::CHAN_ERR_POS +: NCH] = chan_err;
            end
            can_port_pkg::OFS_SYS: begin
                next_rdata[2:0] = sys;
            end
            can_port_pkg::OFS_LED: begin
                next_rdata[NCH-1:0] = TRAFFIC_LED;
                next_rdata[can_port_pkg::LED_STATE_POS +: NCH] = STATE_LED;
            end
            default: begin
                next_slverr = 1'b1;
            end
        endcase
    end

    // bus answer registers
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= can_port_pkg::DATA_ZERO;
        end else begin
            PREADY <= setup_phase;
            PSLVERR <= setup_phase && next_slverr;
            if (setup_phase && !PWRITE) begin
                PRDATA <= next_rdata;
            end
        end
    end

    // two-flop synchronisers for everything arriving on pins
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            err_sync <= 2'b11;
            term_sync <= 2'b00;
            exp_meta <= '0;
            exp_in <= '0;
        end else begin
            err_sync <= {err_sync[0], XCVR_ERR_N_IN};
            term_sync <= {term_sync[0], TERM_SENSE_IN};
            exp_meta <= EXP_PIN_IN;
            exp_in <= exp_meta;
        end
    end

    // transceiver mode lines; the pin levels pick the transceiver mode
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            ctrl <= '0;
            XCVR_EN_OUT <= can_port_pkg::XCVR_EN_RST;
            XCVR_STANDBY_N_OUT <= can_port_pkg::XCVR_STB_RST;
        end else if (wr_hit && PADDR == can_port_pkg::OFS_XCVR_CTRL) begin
            ctrl <= PWDATA[3:0];
            XCVR_EN_OUT <= PWDATA[can_port_pkg::XC_EN_BIT];
            // tied lines cannot differ, so enable governs both
            if (PWDATA[can_port_pkg::XC_TIED_BIT]) begin
                XCVR_STANDBY_N_OUT <= PWDATA[can_port_pkg::XC_EN_BIT];
            end else begin
                XCVR_STANDBY_N_OUT <= PWDATA[can_port_pkg::XC_STB_BIT];
            end
        end
    end

    // expansion port direction and output latch
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            EXP_PIN_OE <= '0;
            EXP_PIN_OUT <= '0;
        end else begin
            if (wr_hit && PADDR == can_port_pkg::OFS_EXP_DIR) begin
                EXP_PIN_OE <= PWDATA[EXP_W-1:0];
            end
            // input pins keep their latch so a later turn-around is glitch free
            if (wr_hit && PADDR == can_port_pkg::OFS_EXP_OUT) begin
                EXP_PIN_OUT <= (PWDATA[EXP_W-1:0] & EXP_PIN_OE) | (EXP_PIN_OUT & ~EXP_PIN_OE);
            end
        end
    end

    // channel and host status; a bus error event beats a clear
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            chan_init <= '0;
            chan_err <= '0;
            sys <= '0;
        end else begin
            if (wr_hit && PADDR == can_port_pkg::OFS_CHAN) begin
                chan_init <= PWDATA[NCH-1:0];
                chan_err <= (chan_err & ~PWDATA[can_port_pkg::CHAN_ERR_POS +: NCH]) | BUS_ERR_EVT;
            end else begin
                chan_err <= chan_err | BUS_ERR_EVT;
            end
            if (wr_hit && PADDR == can_port_pkg::OFS_SYS) begin
                sys <= PWDATA[2:0];
            end
        end
    end

    // shared free-running blink generators, one per pattern
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            pat_lvl <= '0;
            for (int p = 0; p < 3; p++) begin
                pat_cnt[p] <= '0;
            end
        end else begin
            for (int p = 0; p < 3; p++) begin
                if (pat_cnt[p] + 32'h0000_0001 >= (pat_lvl[p] ? PAT_ON[p] : PAT_OFF[p])) begin
                    pat_cnt[p] <= '0;
                    pat_lvl[p] <= !pat_lvl[p];
                end else begin
                    pat_cnt[p] <= pat_cnt[p] + 32'h0000_0001;
                end
            end
        end
    end

    // traffic blink: lit for the first half of the window, then dark
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            TRAFFIC_LED <= '0;
            for (int c = 0; c < NCH; c++) begin
                traffic_cnt[c] <= '0;
            end
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (!chan_init[c]) begin
                    traffic_cnt[c] <= '0;
                    TRAFFIC_LED[c] <= 1'b0;
                end else if (FRAME_EVT[c]) begin
                    traffic_cnt[c] <= TRAFFIC_LEN;
                    TRAFFIC_LED[c] <= 1'b1;
                end else begin
                    if (traffic_cnt[c] != '0) begin
                        traffic_cnt[c] <= traffic_cnt[c] - 32'h0000_0001;
                    end
                    TRAFFIC_LED[c] <= traffic_cnt[c] > TRAFFIC_HALF + 32'h0000_0001;
                end
            end
        end
    end

    // state led per channel, each independent of the others
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            STATE_LED <= '0;
            for (int c = 0; c < NCH; c++) begin
                mode[c] <= can_port_pkg::LED_PAT1;
            end
        end else begin
            for (int c = 0; c < NCH; c++) begin
                mode[c] <= pick_mode(sys, chan_init[c], chan_err[c]);
                case (mode[c])
                    can_port_pkg::LED_OFF: STATE_LED[c] <= 1'b0;
                    can_port_pkg::LED_ON: STATE_LED[c] <= 1'b1;
                    can_port_pkg::LED_PAT1: STATE_LED[c] <= pat_lvl[0];
                    can_port_pkg::LED_PAT2: STATE_LED[c] <= pat_lvl[1];
                    can_port_pkg::LED_PAT3: STATE_LED[c] <= pat_lvl[2];
                    default: STATE_LED[c] <= 1'b0;
                endcase
            end
        end
    end

    tied_lines_a: assert property (@(posedge REF_CLK) disable iff (RST)
        ctrl.tied |-> XCVR_EN_OUT == XCVR_STANDBY_N_OUT)
        else $error("tied transceiver lines differ");

    ctrl_write_a: assert property (@(posedge REF_CLK) disable iff (RST)
        wr_hit && PADDR == can_port_pkg::OFS_XCVR_CTRL && !PWDATA[3]
        |=> XCVR_EN_OUT == $past(PWDATA[0]) && XCVR_STANDBY_N_OUT == $past(PWDATA[1]))
        else $error("transceiver lines did not follow the write");

    err_idle_a: assert property (@(posedge REF_CLK) disable iff (RST)
        setup_phase && !PWRITE && PADDR == can_port_pkg::OFS_XCVR_STAT && ctrl.single_wire
        |=> PREADY && PRDATA[0])
        else $error("single-wire error bit not reported idle");

    exp_inputs_a: assert property (@(posedge REF_CLK) disable iff (RST)
        wr_hit && PADDR == can_port_pkg::OFS_EXP_OUT
        |=> (EXP_PIN_OUT & ~EXP_PIN_OE) == $past(EXP_PIN_OUT & ~EXP_PIN_OE))
        else $error("write changed an input pin latch");

    traffic_dark_a: assert property (@(posedge REF_CLK) disable iff (RST)
        !chan_init[0] && $past(!chan_init[0]) |-> !TRAFFIC_LED[0])
        else $error("traffic led lit on uninitialized channel");

    traffic_blink_a: assert property (@(posedge REF_CLK) disable iff (RST)
        chan_init[0] && FRAME_EVT[0] ##1 chan_init[0] |-> TRAFFIC_LED[0] && traffic_cnt[0] != '0)
        else $error("frame did not start a traffic blink");

    fw_pattern_a: assert property (@(posedge REF_CLK) disable iff (RST)
        sys.fw_update [*2] |-> mode[0] == can_port_pkg::LED_PAT3)
        else $error("firmware update not shown as pattern 3");

    err_sticky_a: assert property (@(posedge REF_CLK) disable iff (RST)
        BUS_ERR_EVT[0] |=> chan_err[0] ##1 mode[0] != can_port_pkg::LED_OFF)
        else $error("bus error event lost");

    apb_ready_a: assert property (@(posedge REF_CLK) disable iff (RST)
        setup_phase |=> PREADY ##1 !PREADY)
        else $error("apb ready not a single access cycle");
endmodule
`default_nettype wire

// [tb/can_port_far_side.sv]
// far-side model: transceiver status lines and user circuitry on the expansion pins
// assumes the block's pin-side outputs feed straight in; purely combinational
`timescale 1ns/100ps
`default_nettype none
module can_port_far_side (
    input wire logic xcvr_en,
    input wire logic xcvr_standby_n,
    input wire logic single_wire,
    input wire logic err_n_req,
    input wire logic term_jumper,
    input wire logic [7:0] user_level,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    output logic err_n,
    output logic term,
    output logic [7:0] pin_in
);
    typedef enum logic [1:0] {SLEEP, WAKE_TX, FAST_TX, NORMAL_TX} sw_mode_t;
    sw_mode_t mode;
    // single-wire mode decode, standby_n is the upper bit
    assign mode = sw_mode_t'({xcvr_standby_n, xcvr_en});
    // single-wire part has no error output, so the line rests idle high
    assign err_n = single_wire ? 1'b1 : err_n_req;
    assign term = term_jumper;
    // block drives a pin only when enabled, else the user circuit sets it
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & user_level);
endmodule
`default_nettype wire

// [tb/can_port_io_and_status_leds_bench.sv]
// self-checking bench for the can port i/o block, apb master tasks per scenario
// assumes the far-side model file and the package are compiled first
`timescale 1ns/100ps
`default_nettype none
`define CHECK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end
module can_port_io_and_status_leds_bench;
    logic REF_CLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0000_0000, PRDATA;
    logic PREADY, PSLVERR, XCVR_EN_OUT, XCVR_STANDBY_N_OUT, XCVR_ERR_N_IN, TERM_SENSE_IN;
    logic [7:0] EXP_PIN_IN, EXP_PIN_OUT, EXP_PIN_OE, user_level = 8'h3C;
    logic [1:0] FRAME_EVT = 2'b00, BUS_ERR_EVT = 2'b00, TRAFFIC_LED, STATE_LED;
    logic single_wire = 1'b0, err_n_req = 1'b1, term_jumper = 1'b0, err;
    logic [31:0] rd;
    logic [7:0] ones;
    logic [7:0] flips;
    int n_mismatch = 0, n_tests = 0;
    // short symmetric blink halves; the toggle count of a window tells the patterns apart
    can_port_io #(.TRAFFIC_CYC(64), .PAT1_ON(4), .PAT2_ON(2), .PAT3_ON(6)) uut (.REF_CLK(REF_CLK),
        .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .XCVR_EN_OUT(XCVR_EN_OUT), .XCVR_STANDBY_N_OUT(XCVR_STANDBY_N_OUT),
        .XCVR_ERR_N_IN(XCVR_ERR_N_IN), .TERM_SENSE_IN(TERM_SENSE_IN), .EXP_PIN_IN(EXP_PIN_IN),
        .EXP_PIN_OUT(EXP_PIN_OUT), .EXP_PIN_OE(EXP_PIN_OE), .FRAME_EVT(FRAME_EVT),
        .BUS_ERR_EVT(BUS_ERR_EVT), .TRAFFIC_LED(TRAFFIC_LED), .STATE_LED(STATE_LED));
    can_port_far_side far (.xcvr_en(XCVR_EN_OUT), .xcvr_standby_n(XCVR_STANDBY_N_OUT),
        .single_wire(single_wire), .err_n_req(err_n_req), .term_jumper(term_jumper),
        .user_level(user_level), .pin_out(EXP_PIN_OUT), .pin_oe(EXP_PIN_OE),
        .err_n(XCVR_ERR_N_IN), .term(TERM_SENSE_IN), .pin_in(EXP_PIN_IN));
    // 100 MHz clock
    initial begin
        forever #5 REF_CLK = ~REF_CLK;
    end
    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge REF_CLK);
        PSEL <= 1'b1; PENABLE <= 1'b0; PWRITE <= w; PADDR <= a; PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge REF_CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 100);
        // a slave that never answers counts against the run
        if (PREADY !== 1'b1) begin
            n_mismatch++;
        end
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0; PENABLE <= 1'b0;
        // let the write edge settle before the caller looks at outputs
        #1;
    endtask
    // count state led high cycles and level changes over a 48-cycle window
    task automatic count_led(input int ch);
        logic prev;
        ones = 8'h00;
        flips = 8'h00;
        repeat (4) @(posedge REF_CLK);
        #1;
        prev = STATE_LED[ch];
        repeat (48) begin
            @(posedge REF_CLK);
            #1;
            ones = ones + {7'h00, STATE_LED[ch]};
            flips = flips + {7'h00, STATE_LED[ch] ^ prev};
            prev = STATE_LED[ch];
        end
    endtask
    // one-cycle event pulse
    task automatic frame(input logic [1:0] m);
        @(posedge REF_CLK);
        FRAME_EVT <= m;
        @(posedge REF_CLK);
        FRAME_EVT <= 2'b00;
    endtask
    task automatic t_reset;
        `CHECK("en", 1'b1, XCVR_EN_OUT)
        `CHECK("stb_n", 1'b1, XCVR_STANDBY_N_OUT)
        `CHECK("oe", 8'h00, EXP_PIN_OE)
        `CHECK("out", 8'h00, EXP_PIN_OUT)
        `CHECK("ready", 1'b0, PREADY)
        `CHECK("traffic", 2'b00, TRAFFIC_LED)
    endtask
    // every single-wire mode, then the tied variant with differing bits
    task automatic t_xcvr;
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, can_port_pkg::OFS_XCVR_CTRL, 32'h0000_0004 | m);
            `CHECK("en", m[0], XCVR_EN_OUT)
            `CHECK("stb_n", m[1], XCVR_STANDBY_N_OUT)
        end
        apb(1'b1, can_port_pkg::OFS_XCVR_CTRL, 32'h0000_0009);
        `CHECK("tied", 2'b11, {XCVR_EN_OUT, XCVR_STANDBY_N_OUT})
        apb(1'b1, can_port_pkg::OFS_XCVR_CTRL, 32'h0000_000A);
        `CHECK("tied", 2'b00, {XCVR_EN_OUT, XCVR_STANDBY_N_OUT})
    endtask
    task automatic t_status;
        err_n_req = 1'b0;
        term_jumper = 1'b1;
        apb(1'b1, can_port_pkg::OFS_XCVR_CTRL, 32'h0000_0003);
        apb(1'b0, can_port_pkg::OFS_XCVR_STAT, 32'h0000_0000);
        `CHECK("stat", 32'h0000_0002, rd)
        // pin still pulled low, so only the block can report the idle level
        apb(1'b1, can_port_pkg::OFS_XCVR_CTRL, 32'h0000_0007);
        apb(1'b0, can_port_pkg::OFS_XCVR_STAT, 32'h0000_0000);
        `CHECK("stat_sw", 32'h0000_0003, rd)
        // single-wire part fitted: its error line rests high on the pin
        single_wire = 1'b1;
        apb(1'b1, can_port_pkg::OFS_XCVR_CTRL, 32'h0000_0003);
        apb(1'b0, can_port_pkg::OFS_XCVR_STAT, 32'h0000_0000);
        `CHECK("stat_pin", 32'h0000_0003, rd)
    endtask
    // low nibble as outputs, high nibble read from the user circuit
    task automatic t_exp;
        apb(1'b1, can_port_pkg::OFS_EXP_DIR, 32'h0000_000F);
        apb(1'b1, can_port_pkg::OFS_EXP_OUT, 32'h0000_00A5);
        `CHECK("oe", 8'h0F, EXP_PIN_OE)
        `CHECK("out", 8'h05, EXP_PIN_OUT)
        apb(1'b0, can_port_pkg::OFS_EXP_DIR, 32'h0000_0000);
        `CHECK("dir_rd", 32'h0000_000F, rd)
        apb(1'b0, can_port_pkg::OFS_EXP_OUT, 32'h0000_0000);
        `CHECK("out_rd", 32'h0000_0005, rd)
        repeat (3) @(posedge REF_CLK);
        apb(1'b0, can_port_pkg::OFS_EXP_IN, 32'h0000_0000);
        `CHECK("exp_in", 32'h0000_0035, rd)
        `CHECK("slverr", 1'b0, err)
        apb(1'b0, 8'h20, 32'h0000_0000);
        `CHECK("unmapped", 1'b1, err)
    endtask
    task automatic t_state;
        count_led(0);
        `CHECK("login", 8'h18, ones)
        `CHECK("login_tgl", 8'h0C, flips)
        apb(1'b1, can_port_pkg::OFS_SYS, 32'h0000_0001);
        count_led(0);
        `CHECK("ready", 8'h30, ones)
        apb(1'b1, can_port_pkg::OFS_SYS, 32'h0000_0003);
        count_led(0);
        `CHECK("cable", 8'h18, ones)
        `CHECK("cable_tgl", 8'h0C, flips)
        apb(1'b1, can_port_pkg::OFS_SYS, 32'h0000_0001);
        apb(1'b1, can_port_pkg::OFS_CHAN, 32'h0000_0001);
        count_led(0);
        `CHECK("init", 8'h00, ones)
        @(posedge REF_CLK);
        BUS_ERR_EVT <= 2'b01;
        @(posedge REF_CLK);
        BUS_ERR_EVT <= 2'b00;
        count_led(0);
        `CHECK("buserr", 8'h18, ones)
        `CHECK("buserr_tgl", 8'h18, flips)
        count_led(1);
        `CHECK("other", 8'h30, ones)
        apb(1'b1, can_port_pkg::OFS_SYS, 32'h0000_0005);
        count_led(0);
        `CHECK("fwupd", 8'h18, ones)
        `CHECK("fwupd_tgl", 8'h08, flips)
        // clearing the sticky error returns an initialized channel to dark
        apb(1'b1, can_port_pkg::OFS_SYS, 32'h0000_0001);
        apb(1'b1, can_port_pkg::OFS_CHAN, 32'h0000_0101);
        count_led(0);
        `CHECK("cleared", 8'h00, ones)
    endtask
    // channel 0 initialized, channel 1 not; a second frame restarts the blink
    task automatic t_traffic;
        apb(1'b1, can_port_pkg::OFS_CHAN, 32'h0000_0001);
        frame(2'b11);
        #1;
        `CHECK("blink", 2'b01, TRAFFIC_LED)
        repeat (20) @(posedge REF_CLK);
        frame(2'b01);
        repeat (25) @(posedge REF_CLK);
        #1;
        `CHECK("restart", 1'b1, TRAFFIC_LED[0])
        repeat (64) @(posedge REF_CLK);
        #1;
        `CHECK("dark", 2'b00, TRAFFIC_LED)
        // back to uninitialized so the state led scenario starts clean
        apb(1'b1, can_port_pkg::OFS_CHAN, 32'h0000_0000);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (16) @(posedge REF_CLK);
        RST <= 1'b0;
        @(posedge REF_CLK);
        #1;
        t_reset();
        t_xcvr();
        t_status();
        t_exp();
        t_traffic();
        t_state();
        stop_test();
    end
    // watchdog, generous against roughly 650 cycles of tests
    initial begin
        #200000;
        n_mismatch++;
        stop_test();
    end
endmodule
`default_nettype wire
